// ===== rtl/raiv_map.svh
`ifndef RAIV_MAP_SVH
`define RAIV_MAP_SVH
// Function
// - ten interrupt sources plus reset, each with its own vector
// - request taken only when its enable and global enable are both one
// - vectors: reset 000, external_request_0 001 through comparator 00A
// - lowest vector address wins; reset first, then external request 0
// - reset pin low longer than 50 ns resets, even without clock
// - enabled watchdog expiry is a third reset source
// - reset returns registers to initial values; fetch starts at 000
// - start-up counter on watchdog oscillator: 256 fast, 16K slow
// - after power-on, core held until start-up time-out completes
// - on reset pin release, counter starts; core released after full time-out
// - holding reset pin low lengthens power-on reset; time-out starts on release
// - watchdog reset is one clock pulse; time-out starts at its fall
// - accepting clears global enable; return or software sets it again
// - persistent conditions set flag only on the event edge
// - vectoring clears the flag that caused the interrupt
// - writing one clears a flag; writing zero leaves it
// - flags set even while individual enable is zero and stay pending
// - pending flags serviced in priority order once global enable set
// - level-sensed external request has no latched flag
// - status register neither saved nor restored on entry or return
// - enables held in three 8-bit registers: general mask, timer mask and control

`define RAIV_NUM_SRC        10
`define RAIV_VEC_RESET      4'h0
`define RAIV_START_FAST     16'h0100
`define RAIV_START_SLOW     16'h4000
`define RAIV_PIN_MIN_NS     50
`define RAIV_CLK_NS         50

`define RAIV_ADDR_GMASK     8'h00
`define RAIV_ADDR_TMASK     8'h04
`define RAIV_ADDR_FLAGS     8'h08
`define RAIV_ADDR_CTRL      8'h0C
`define RAIV_ADDR_STAT      8'h10

`define RAIV_GM_EXT1        7
`define RAIV_GM_EXT0        6
`define RAIV_TM_T1OVF       7
`define RAIV_TM_T1CMP       6
`define RAIV_TM_T1CAP       3
`define RAIV_TM_T0OVF       1
`define RAIV_GMASK_RST      8'h00
`define RAIV_TMASK_RST      8'h00
`define RAIV_CTRL_RST       8'h00
`define RAIV_CTRL_UART_RX   0
`define RAIV_CTRL_UART_DRE  1
`define RAIV_CTRL_UART_TXC  2
`define RAIV_CTRL_CMP       3
`define RAIV_CTRL_LVL0      4
`define RAIV_CTRL_LVL1      5
`define RAIV_CTRL_GIE       7
`endif

// ===== rtl/raiv_pkg.sv
package raiv_pkg;
    typedef enum logic [1:0] {
        RAIV_HOLD = 2'b00,
        RAIV_COUNT = 2'b01,
        RAIV_RUN = 2'b10
    } raiv_rst_e;

    typedef struct packed {
        logic       req;
        logic [3:0] vec;
    } raiv_irq_s;

    typedef struct packed {
        logic [7:0] awaddr;
        logic       awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic       wvalid;
        logic       bready;
        logic [7:0] araddr;
        logic       arvalid;
        logic       rready;
    } raiv_axi_req_s;
endpackage

// ===== rtl/raiv_ctrl.sv
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`include "raiv_map.svh"
module raiv_ctrl #(
    parameter int unsigned START_FAST = 256,
    parameter int unsigned START_SLOW = 16384
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        por,
    input  wire logic        reset_pin_n,
    input  wire logic        wdt_osc_tick,
    input  wire logic        wdt_enable,
    input  wire logic        wdt_expire,
    input  wire logic        fast_start_fuse,
    input  wire logic [9:0]  src_event,
    input  wire logic        ext0_pin_low,
    input  wire logic        ext1_pin_low,
    input  wire logic        irq_ack,
    input  wire logic        return_from_interrupt,
    input  wire logic        s_awvalid,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_wvalid,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_bready,
    input  wire logic        s_arvalid,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_rready,
    output logic             s_awready,
    output logic             s_wready,
    output logic             s_bvalid,
    output logic [1:0]       s_bresp,
    output logic             s_arready,
    output logic             s_rvalid,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             core_reset,
    output logic             irq_req,
    output logic [3:0]       irq_vec,
    output logic             global_enable
);
    // source order by vector: ext0, ext1, t1cap, t1cmp, t1ovf, t0ovf, rx, dre, txc, cmp
    localparam int PIN_CYC = (`RAIV_PIN_MIN_NS + `RAIV_CLK_NS - 1) / `RAIV_CLK_NS;

    logic [1:0]  pin_sync_q;
    logic        pin_low_q;
    logic [1:0]  lvl_q;
    logic [9:0]  ev_sync1_q;
    logic [9:0]  ev_sync2_q;
    logic [9:0]  ev_prev_q;
    logic        rst_src;
    logic        wdt_pulse_q;
    raiv_pkg::raiv_rst_e rst_state_q;
    logic [14:0] start_cnt_q;
    logic [7:0]  gmask_q;
    logic [7:0]  tmask_q;
    logic [7:0]  ctrl_q;
    logic [9:0]  flag_q;
    logic [9:0]  enable_vec;
    logic [9:0]  pending;
    logic [9:0]  rise;
    logic [9:0]  sw_clear;
    logic [9:0]  ack_clear;
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        do_write;
    logic        gie_q;
    logic [3:0]  win_idx;
    logic        win_any;
    logic [31:0] rd_word;
    logic        rd_ok;
    logic [14:0] start_len;

    // pin is sampled twice to cut metastability; a filter below needs PIN_CYC lows
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_sync_q <= 2'h3;
            ev_sync1_q <= 10'h000;
            ev_sync2_q <= 10'h000;
        end else begin
            pin_sync_q <= {pin_sync_q[0], reset_pin_n};
            ev_sync1_q <= src_event;
            ev_sync2_q <= ev_sync1_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lvl_q <= 2'h0;
        end else begin
            lvl_q <= {ext1_pin_low, ext0_pin_low};
        end
    end

    // the pin also acts asynchronously via rst at chip level, so stopped clock still resets
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_low_q <= 1'b1;
        end else begin
            pin_low_q <= ~pin_sync_q[1] && (PIN_CYC <= 1 || ~pin_sync_q[0]);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wdt_pulse_q <= 1'b0;
        end else begin
            wdt_pulse_q <= wdt_enable && wdt_expire && !wdt_pulse_q;
        end
    end

    assign rst_src = por || pin_low_q || wdt_pulse_q;
    assign start_len = fast_start_fuse ? 15'(START_FAST - 1) : 15'(START_SLOW - 1);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rst_state_q <= raiv_pkg::RAIV_HOLD;
            start_cnt_q <= 15'h0000;
            core_reset  <= 1'b1;
        end else if (rst_src) begin
            rst_state_q <= raiv_pkg::RAIV_HOLD;
            start_cnt_q <= 15'h0000;
            core_reset  <= 1'b1;
        end else begin
            unique case (rst_state_q)
                raiv_pkg::RAIV_HOLD: begin
                    rst_state_q <= raiv_pkg::RAIV_COUNT;
                end
                raiv_pkg::RAIV_COUNT: begin
                    if (wdt_osc_tick) begin
                        if (start_cnt_q == start_len) begin
                            rst_state_q <= raiv_pkg::RAIV_RUN;
                            core_reset  <= 1'b0;
                        end else begin
                            start_cnt_q <= start_cnt_q + 15'h0001;
                        end
                    end
                end
                raiv_pkg::RAIV_RUN: begin
                    core_reset <= 1'b0;
                end
                default: begin
                    rst_state_q <= raiv_pkg::RAIV_HOLD;
                end
            endcase
        end
    end

    assign enable_vec = {ctrl_q[`RAIV_CTRL_CMP], ctrl_q[`RAIV_CTRL_UART_TXC],
                         ctrl_q[`RAIV_CTRL_UART_DRE], ctrl_q[`RAIV_CTRL_UART_RX],
                         tmask_q[`RAIV_TM_T0OVF], tmask_q[`RAIV_TM_T1OVF],
                         tmask_q[`RAIV_TM_T1CMP], tmask_q[`RAIV_TM_T1CAP],
                         gmask_q[`RAIV_GM_EXT1], gmask_q[`RAIV_GM_EXT0]};

    assign rise = ev_sync2_q & ~ev_prev_q;
    assign do_write = aw_have_q && w_have_q && !s_bvalid;
    assign sw_clear = (do_write && aw_addr_q == `RAIV_ADDR_FLAGS && w_strb_q[0] && w_strb_q[1])
                      ? w_data_q[9:0] : 10'h000;

    genvar gi;
    generate
        for (gi = 0; gi < `RAIV_NUM_SRC; gi++) begin : g_src
            assign ack_clear[gi] = irq_ack && irq_vec == 4'(gi + 1);
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ev_prev_q <= 10'h000;
            flag_q    <= 10'h000;
        end else begin
            ev_prev_q <= ev_sync2_q;
            // new event beats a same-cycle clear; flags latch regardless of enables
            flag_q <= rst_src ? 10'h000 : (rise | (flag_q & ~sw_clear & ~ack_clear));
        end
    end

    // level mode bypasses the flag; the bit only follows the pin
    assign pending = {flag_q[9:2],
                      ctrl_q[`RAIV_CTRL_LVL1] ? lvl_q[1] : flag_q[1],
                      ctrl_q[`RAIV_CTRL_LVL0] ? lvl_q[0] : flag_q[0]} & enable_vec;

    always_comb begin
        win_idx = 4'h0;
        win_any = 1'b0;
        for (int i = `RAIV_NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                win_idx = 4'(i + 1);
                win_any = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_req <= 1'b0;
            irq_vec <= `RAIV_VEC_RESET;
        end else begin
            irq_req <= win_any && gie_q && !core_reset && !irq_ack;
            irq_vec <= win_any ? win_idx : `RAIV_VEC_RESET;
        end
    end

    // only the enable bit moves on entry and return; other status stays with software
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gie_q <= 1'b0;
        end else if (rst_src) begin
            gie_q <= 1'b0;
        end else if (irq_ack) begin
            gie_q <= 1'b0;
        end else if (return_from_interrupt) begin
            gie_q <= 1'b1;
        end else if (do_write && aw_addr_q == `RAIV_ADDR_CTRL && w_strb_q[0]) begin
            gie_q <= w_data_q[`RAIV_CTRL_GIE];
        end
    end

    // mirror of the enable, same cycle, so the core never sees a stale copy
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            global_enable <= 1'b0;
        end else if (rst_src) begin
            global_enable <= 1'b0;
        end else if (irq_ack) begin
            global_enable <= 1'b0;
        end else if (return_from_interrupt) begin
            global_enable <= 1'b1;
        end else if (do_write && aw_addr_q == `RAIV_ADDR_CTRL && w_strb_q[0]) begin
            global_enable <= w_data_q[`RAIV_CTRL_GIE];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gmask_q <= `RAIV_GMASK_RST;
            tmask_q <= `RAIV_TMASK_RST;
            ctrl_q  <= `RAIV_CTRL_RST;
        end else if (rst_src) begin
            gmask_q <= `RAIV_GMASK_RST;
            tmask_q <= `RAIV_TMASK_RST;
            ctrl_q  <= `RAIV_CTRL_RST;
        end else if (do_write && w_strb_q[0]) begin
            if (aw_addr_q == `RAIV_ADDR_GMASK) begin
                gmask_q <= w_data_q[7:0] & 8'hC0;
            end
            if (aw_addr_q == `RAIV_ADDR_TMASK) begin
                tmask_q <= w_data_q[7:0] & 8'hCA;
            end
            if (aw_addr_q == `RAIV_ADDR_CTRL) begin
                ctrl_q <= w_data_q[7:0] & 8'h3F;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            s_bvalid  <= 1'b0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {s_awaddr[7:2], 2'b00};
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_wdata;
                w_strb_q <= s_wstrb;
            end
            if (do_write) begin
                s_bvalid  <= 1'b1;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    assign s_awready = !aw_have_q && !s_bvalid;
    assign s_wready  = !w_have_q && !s_bvalid;
    assign s_bresp   = 2'b00;
    assign s_rresp   = 2'b00;

    always_comb begin
        rd_word = 32'h00000000;
        rd_ok   = 1'b1;
        unique case ({s_araddr[7:2], 2'b00})
            `RAIV_ADDR_GMASK: rd_word = {24'h000000, gmask_q};
            `RAIV_ADDR_TMASK: rd_word = {24'h000000, tmask_q};
            `RAIV_ADDR_FLAGS: rd_word = {22'h000000, flag_q};
            `RAIV_ADDR_CTRL:  rd_word = {24'h000000, gie_q, 1'b0, ctrl_q[5:0]};
            `RAIV_ADDR_STAT:  rd_word = {22'h000000, core_reset, 1'b0, rst_state_q, 2'b00, irq_vec};
            default:          rd_ok   = 1'b0;
        endcase
    end

    // unmapped reads return zero with OKAY; this block has no fault cases to signal
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h00000000;
        end else begin
            s_arready <= 1'b0;
            if (s_arvalid && !s_rvalid && !s_arready) begin
                s_arready <= 1'b1;
                s_rvalid  <= 1'b1;
                s_rdata   <= rd_ok ? rd_word : 32'h00000000;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ===== sim/raiv_monitor.sv
module raiv_monitor (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       reset_pin_n,
    input wire logic       wdt_enable,
    input wire logic       wdt_expire,
    input wire logic       irq_ack,
    input wire logic       return_from_interrupt,
    input wire logic       s_bvalid,
    input wire logic       s_bready,
    input wire logic       core_reset,
    input wire logic       irq_req,
    input wire logic [3:0] irq_vec,
    input wire logic       global_enable
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    ack_clears_gie_a: assert property (irq_ack && irq_req |=> !global_enable)
        else $error("global enable kept after acknowledge");
    return_from_interrupt_sets_gie_a: assert property (return_from_interrupt |=> global_enable)
        else $error("global enable not set by return");
    ack_drops_req_a: assert property (irq_ack |=> !irq_req)
        else $error("request kept after acknowledge");
    gie_gates_req_a: assert property ((!global_enable) [*2] |-> !irq_req)
        else $error("request without global enable");
    vec_range_a: assert property (irq_req |-> irq_vec inside {[4'h1:4'hA]})
        else $error("vector out of range");
    startup_hold_a: assert property ($fell(rst) |-> core_reset [*4])
        else $error("core released too early");
    pin_reset_a: assert property (!reset_pin_n [*5] |-> core_reset)
        else $error("reset pin ignored");
    wdt_reset_a: assert property (wdt_enable && wdt_expire |=> ##[0:2] core_reset)
        else $error("watchdog expiry ignored");
    bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("write response dropped");
    c_vec10: cover property (irq_ack && irq_vec == 4'hA);
    c_return_from_interrupt: cover property (return_from_interrupt);
    c_release: cover property ($fell(core_reset));
endmodule

bind raiv_ctrl raiv_monitor u_mon (
    .ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n), .wdt_enable(wdt_enable),
    .wdt_expire(wdt_expire), .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .core_reset(core_reset), .irq_req(irq_req),
    .irq_vec(irq_vec), .global_enable(global_enable)
);

// ===== sim/raiv_core_model.sv
module raiv_core_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       serve,
    input  wire logic       core_reset,
    input  wire logic       irq_req,
    input  wire logic [3:0] irq_vec,
    output logic            irq_ack,
    output logic            return_from_interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] vec_log [8];
    int         n_log;
    int         busy;
    // fixed handler length; the bench only sees the order of vectors taken
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_ack <= 1'b0;
            return_from_interrupt <= 1'b0;
            n_log <= 0;
            busy <= 0;
        end else begin
            irq_ack <= 1'b0;
            return_from_interrupt <= 1'b0;
            if (busy > 0) begin
                busy <= busy - 1;
                return_from_interrupt <= (busy == 1);
            end else if (serve && irq_req && !irq_ack && !core_reset) begin
                irq_ack <= 1'b1;
                vec_log[n_log[2:0]] <= irq_vec;
                n_log <= n_log + 1;
                busy <= 4;
            end
        end
    end
endmodule

// ===== sim/reset_and_interrupt_vectoring_bench.sv
`include "raiv_map.svh"
`define CHK(nm, ex, got) \
    begin \
        cmp_count++; \
        if ((got) !== (ex)) begin \
            err_total++; \
            $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
        end \
    end
module reset_and_interrupt_vectoring_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FAST = 4;
    localparam int SLOW = 8;
    logic        ref_clk = 0, rst = 1, por = 1, reset_pin_n = 1, wdt_osc_tick = 0;
    logic        wdt_enable = 0, wdt_expire = 0, fast_start_fuse = 1, serve = 0;
    logic        ext0_pin_low = 0, ext1_pin_low = 0, s_awvalid = 0, s_wvalid = 0;
    logic        s_bready = 0, s_arvalid = 0, s_rready = 0, s_awready, s_wready;
    logic        s_bvalid, s_arvalid_q, s_arready, s_rvalid, core_reset, irq_req;
    logic        global_enable, irq_ack, return_from_interrupt;
    logic [9:0]  src_event = 10'h000;
    logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata, rd_q;
    logic [3:0]  s_wstrb = 4'hF, irq_vec;
    logic [1:0]  s_bresp, s_rresp;
    int          err_total = 0, cmp_count = 0, n;
    raiv_ctrl #(.START_FAST(FAST), .START_SLOW(SLOW)) u_dut (.*);
    raiv_core_model u_core (.*);
    always #25 ref_clk = ~ref_clk;
    // watchdog oscillator at half the system rate
    always @(posedge ref_clk) wdt_osc_tick <= ~wdt_osc_tick;
    task automatic results;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tmo;
        err_total++;
        results();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) break;
        end
        s_bready <= 1'b0;
        if (n == 50) tmo();
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) break;
        end
        rd_q = s_rdata;
        s_rready <= 1'b0;
        if (n == 50) tmo();
    endtask
    task automatic wait_run;
        for (n = 0; n < 300 && core_reset !== 1'b0; n++) @(posedge ref_clk);
        if (n == 300) tmo();
    endtask
    task automatic ev(input logic [9:0] m);
        @(posedge ref_clk);
        src_event <= m;
        cyc(2);
        src_event <= 10'h000;
        cyc(6);
    endtask
    task automatic t_startup;
        cyc(10);
        `CHK("held", 1'b1, core_reset)
        por <= 1'b0;
        wait_run();
        `CHK("fast count", 1'b1, n >= 2 * FAST - 1 && n <= 2 * FAST + 6)
        rd(`RAIV_ADDR_GMASK);
        `CHK("gmask", 32'h0, rd_q)
        rd(`RAIV_ADDR_TMASK);
        `CHK("tmask", 32'h0, rd_q)
        rd(8'h20);
        `CHK("unmapped", 32'h0, rd_q)
    endtask
    task automatic t_vectors;
        ev(10'h206);
        rd(`RAIV_ADDR_FLAGS);
        `CHK("pending", 32'h206, rd_q)
        wr(`RAIV_ADDR_GMASK, 32'h80);
        wr(`RAIV_ADDR_TMASK, 32'h08);
        wr(`RAIV_ADDR_CTRL, 32'h08);
        cyc(3);
        `CHK("no gie", 1'b0, irq_req)
        serve <= 1'b1;
        wr(`RAIV_ADDR_CTRL, 32'h88);
        for (n = 0; n < 100 && u_core.n_log < 3; n++) cyc(1);
        if (n == 100) tmo();
        `CHK("order", 12'h23A, {u_core.vec_log[0], u_core.vec_log[1], u_core.vec_log[2]})
        cyc(8);
        serve <= 1'b0;
        rd(`RAIV_ADDR_FLAGS);
        `CHK("auto clear", 32'h0, rd_q)
        rd(`RAIV_ADDR_CTRL);
        `CHK("gie back", 32'h88, rd_q)
    endtask
    task automatic t_flags;
        ev(10'h001);
        `CHK("masked", 1'b0, irq_req)
        wr(`RAIV_ADDR_FLAGS, 32'h0);
        rd(`RAIV_ADDR_FLAGS);
        `CHK("write zero", 32'h1, rd_q)
        wr(`RAIV_ADDR_FLAGS, 32'h1);
        rd(`RAIV_ADDR_FLAGS);
        `CHK("write one", 32'h0, rd_q)
        src_event <= 10'h008;
        cyc(6);
        wr(`RAIV_ADDR_FLAGS, 32'h8);
        cyc(4);
        rd(`RAIV_ADDR_FLAGS);
        `CHK("persist", 32'h0, rd_q)
        src_event <= 10'h000;
    endtask
    task automatic t_level;
        wr(`RAIV_ADDR_GMASK, 32'h40);
        wr(`RAIV_ADDR_CTRL, 32'h90);
        ext0_pin_low <= 1'b1;
        cyc(4);
        `CHK("level vec", 4'h1, irq_vec)
        rd(`RAIV_ADDR_FLAGS);
        `CHK("no flag", 32'h0, rd_q)
        ext0_pin_low <= 1'b0;
        cyc(3);
        `CHK("level gone", 1'b0, irq_req)
    endtask
    task automatic t_pin;
        fast_start_fuse <= 1'b0;
        reset_pin_n <= 1'b0;
        cyc(6);
        `CHK("pin", 1'b1, core_reset)
        reset_pin_n <= 1'b1;
        wait_run();
        `CHK("slow count", 1'b1, n >= 2 * SLOW - 1)
        rd(`RAIV_ADDR_CTRL);
        `CHK("ctrl reset", 32'h0, rd_q)
        fast_start_fuse <= 1'b1;
    endtask
    task automatic t_wdt;
        wdt_expire <= 1'b1;
        cyc(1);
        wdt_expire <= 1'b0;
        cyc(4);
        `CHK("wdt off", 1'b0, core_reset)
        wdt_enable <= 1'b1;
        wdt_expire <= 1'b1;
        cyc(1);
        wdt_expire <= 1'b0;
        cyc(2);
        `CHK("wdt on", 1'b1, core_reset)
        wait_run();
        `CHK("wdt delay", 1'b1, n >= 2 * FAST - 3)
        wdt_enable <= 1'b0;
    endtask
    initial begin
        cyc(4);
        rst <= 1'b0;
        t_startup();
        t_vectors();
        t_flags();
        t_level();
        t_pin();
        t_wdt();
        results();
    end
endmodule
